// *** hw/rmc_readback_cmds.sv ***
// Manufacturer readback commands: alarms, input readback, revisions, run timer, storage.
`timescale 1ns/100ps
module rmc_readback_cmds #(
   parameter logic [39:0] HOUR_CYCLES = rmc_pkg::HOUR_CYCLES_DFLT
) (
   input  wire logic                           clk,
   input  wire logic                           rstn,
   input  wire rmc_pkg::rmc_link_in_t          link_in,
   input  wire logic [15:0]                    share_ma,
   input  wire logic [15:0]                    vin_word,
   input  wire logic [15:0]                    pin_word,
   input  wire logic [47:0]                    fw_revs,
   input  wire logic [7:0]                     sec_alarm_pins,
   input  wire logic [7:0]                     pri_alarm_pins,
   input  wire logic                           hours_load,
   input  wire logic [rmc_pkg::HOURS_W-1:0]    hours_preset,
   input  wire logic                           err_clear,
   output rmc_pkg::rmc_link_out_t              link_out_ff,
   output logic [7:0]                          secondary_alarm_flags_ff,
   output logic [7:0]                          primary_alarm_flags_ff,
   output logic [rmc_pkg::HOURS_W-1:0]         hours_ff,
   output logic                                pec_error_ff,
   output logic                                range_error_ff
);
   import rmc_pkg::*;

   rmc_state_t    st_ff, nxt_st;
   rmc_link_out_t nxt_out;
   logic [7:0]    cmd_ff, nxt_cmd, loc_ff, nxt_loc, idx_ff, nxt_idx;
   logic [7:0]    pend_ff, nxt_pend, wptr_ff, nxt_wptr, cnt_ff, nxt_cnt;
   logic [7:0]    crc_ff, nxt_crc, crc_prev_ff, nxt_crc_prev;
   logic          pend_vld_ff, nxt_pend_vld;
   logic          nxt_pec_err, nxt_range_err, pec_hit, range_hit;
   logic [15:0]   pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_stable_ff, nxt_pin_stable;
   logic          pwr_ff, nxt_pwr;
   logic [7:0]    nxt_sec_alarm, nxt_pri_alarm;
   logic [39:0]   cyc_ff, nxt_cyc;
   logic [HOURS_W-1:0] nxt_hours;
   logic [7:0]    nv_mem [NV_SIZE];
   logic          mem_we;
   logic [6:0]    mem_wa;
   logic [7:0]    mem_wd;
   logic [7:0]    resp_cnt, resp_byte, data_byte;
   logic          range_ok;

   // Alarm pins are filtered; a bit moves once its second and third stages agree.
   always_comb
   begin
      for (int b = 0; b < 16; b++)
      begin
         nxt_pin_stable[b] = (pin_s2_ff[b] == pin_s3_ff[b]) ? pin_s3_ff[b] : pin_stable_ff[b];
      end
      nxt_pwr       = share_ma > SHARE_LIMIT_MA;                         // [R1]
      nxt_sec_alarm = {pin_stable_ff[15:9], pwr_ff};                     // [R1]
      nxt_pri_alarm = pin_stable_ff[7:0];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_s1_ff                <= '0;
         pin_s2_ff                <= '0;
         pin_s3_ff                <= '0;
         pin_stable_ff            <= '0;
         pwr_ff                   <= 1'b0;
         secondary_alarm_flags_ff <= ALARM_RST;
         primary_alarm_flags_ff   <= ALARM_RST;
      end
      else
      begin
         pin_s1_ff                <= {sec_alarm_pins, pri_alarm_pins};
         pin_s2_ff                <= pin_s1_ff;
         pin_s3_ff                <= pin_s2_ff;
         pin_stable_ff            <= nxt_pin_stable;
         pwr_ff                   <= nxt_pwr;
         secondary_alarm_flags_ff <= nxt_sec_alarm;
         primary_alarm_flags_ff   <= nxt_pri_alarm;
      end
   end

   // Hour counter runs whatever the output state and saturates when full.
   always_comb
   begin
      nxt_cyc   = cyc_ff + 40'h1;
      nxt_hours = hours_ff;
      if (hours_load)
      begin
         nxt_cyc   = '0;
         nxt_hours = hours_preset;
      end
      else if (cyc_ff >= HOUR_CYCLES - 40'h1)
      begin
         nxt_cyc = '0;                                                   // [R5]
         if (hours_ff != {HOURS_W{1'b1}})
         begin
            nxt_hours = hours_ff + {{(HOURS_W-1){1'b0}}, 1'b1};          // [R6]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cyc_ff   <= '0;
         hours_ff <= '0;
      end
      else
      begin
         cyc_ff   <= nxt_cyc;
         hours_ff <= nxt_hours;
      end
   end

   // Answer byte for the current read position.
   always_comb
   begin
      range_ok = ({1'b0, loc_ff} + {1'b0, cnt_ff} <= NV_SIZE) && (cnt_ff <= NV_MAX_COUNT);
      if (cmd_ff == CMD_INPUT)
         resp_cnt = INPUT_COUNT;                                         // [R2]
      else if (cmd_ff == CMD_FWREV)
         resp_cnt = FWREV_COUNT;                                         // [R3]
      else if (cmd_ff == CMD_TIMER)
         resp_cnt = TIMER_COUNT;                                         // [R4]
      else if (cmd_ff == CMD_NVDATA && range_ok)
         resp_cnt = cnt_ff;                                              // [R9]
      else
         resp_cnt = 8'h00;                                               // [R13]
      case (cmd_ff)
         CMD_INPUT:  data_byte = (idx_ff[2] || idx_ff[1:0] == 2'b11)
                                 ? pin_word[{idx_ff[2], 3'b000} +: 8]
                                 : vin_word[{idx_ff[1], 3'b000} +: 8];                // [R11]
         CMD_FWREV:  data_byte = fw_revs[{idx_ff[2:0] - 3'h1, 3'b000} +: 8];          // [R3]
         CMD_TIMER:  data_byte = hours_ff[{idx_ff[1:0] - 2'h1, 3'b000} +: 8];         // [R4]
         CMD_NVDATA: data_byte = nv_mem[7'(loc_ff + idx_ff - 8'h01)];                 // [R7]
         default:    data_byte = IDLE_BYTE;
      endcase
      if (idx_ff == 8'h00)
         resp_byte = resp_cnt;                                           // [R10]
      else if (idx_ff <= resp_cnt)
         resp_byte = data_byte;
      else if (idx_ff == resp_cnt + 8'h01)
         resp_byte = crc_ff;
      else
         resp_byte = IDLE_BYTE;
   end

   // Transaction tracking: command capture, storage writes, read answers.
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_cmd      = cmd_ff;
      nxt_loc      = loc_ff;
      nxt_idx      = idx_ff;
      nxt_pend     = pend_ff;
      nxt_pend_vld = pend_vld_ff;
      nxt_wptr     = wptr_ff;
      nxt_cnt      = cnt_ff;
      nxt_crc      = crc_ff;
      nxt_crc_prev = crc_prev_ff;
      nxt_out      = '{rd_valid: 1'b0, rd_data: link_out_ff.rd_data};
      mem_we       = 1'b0;
      mem_wa       = wptr_ff[6:0];
      mem_wd       = pend_ff;
      pec_hit      = 1'b0;
      range_hit    = 1'b0;
      if (link_in.frame_start)
      begin
         nxt_st       = ST_IDLE;
         nxt_crc      = 8'h00;
         nxt_idx      = 8'h00;
         nxt_pend_vld = 1'b0;
      end
      else if (link_in.frame_stop)
      begin
         // The last byte of a storage write is its PEC.
         if (st_ff == ST_WRITE && cmd_ff == CMD_NVDATA && pend_vld_ff)
         begin
            pec_hit = pend_ff != crc_prev_ff;                            // [R8]
         end
         nxt_st = ST_IDLE;                                               // [R12]
      end
      else if (link_in.byte_valid)
      begin
         nxt_crc_prev = crc_ff;
         nxt_crc      = rmc_crc8(crc_ff, link_in.byte_data);
         nxt_idx      = 8'h00;
         if (link_in.byte_addr && link_in.byte_data[0])
         begin
            nxt_st = ST_READ;
            if (cmd_ff == CMD_NVDATA && pend_vld_ff)
            begin
               nxt_cnt      = pend_ff;                                   // [R9]
               nxt_pend_vld = 1'b0;
            end
         end
         else if (link_in.byte_addr)
         begin
            nxt_st       = ST_WRITE;
            nxt_pend_vld = 1'b0;
         end
         else if (st_ff == ST_WRITE)
         begin
            nxt_idx = (idx_ff == 8'hFF) ? idx_ff : idx_ff + 8'h01;
            if (idx_ff == 8'h00)
               nxt_cmd = link_in.byte_data;
            else if (idx_ff == 8'h01)
            begin
               nxt_loc  = link_in.byte_data;
               nxt_wptr = link_in.byte_data;
            end
            else
            begin
               // A byte is stored only once a later byte proves it was not the PEC.
               if (pend_vld_ff && cmd_ff == CMD_NVDATA)
               begin
                  if ({1'b0, wptr_ff} < NV_SIZE)
                  begin
                     mem_we   = 1'b1;                                    // [R8]
                     nxt_wptr = wptr_ff + 8'h01;
                  end
                  else
                     range_hit = 1'b1;                                   // [R13]
               end
               nxt_pend     = link_in.byte_data;
               nxt_pend_vld = 1'b1;
            end
         end
      end
      else if (link_in.rd_req && st_ff == ST_READ)
      begin
         nxt_out.rd_valid = 1'b1;
         nxt_out.rd_data  = resp_byte;
         nxt_crc          = rmc_crc8(crc_ff, resp_byte);
         nxt_idx          = (idx_ff == 8'hFF) ? idx_ff : idx_ff + 8'h01;
         range_hit        = (idx_ff == 8'h00) && (cmd_ff == CMD_NVDATA) && !range_ok; // [R13]
      end
      nxt_pec_err   = (pec_error_ff & ~err_clear) | pec_hit;
      nxt_range_err = (range_error_ff & ~err_clear) | range_hit;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff          <= ST_IDLE;
         cmd_ff         <= 8'h00;
         loc_ff         <= 8'h00;
         idx_ff         <= 8'h00;
         pend_ff        <= 8'h00;
         pend_vld_ff    <= 1'b0;
         wptr_ff        <= 8'h00;
         cnt_ff         <= 8'h00;
         crc_ff         <= 8'h00;
         crc_prev_ff    <= 8'h00;
         link_out_ff    <= '0;
         pec_error_ff   <= 1'b0;
         range_error_ff <= 1'b0;
      end
      else
      begin
         st_ff          <= nxt_st;
         cmd_ff         <= nxt_cmd;
         loc_ff         <= nxt_loc;
         idx_ff         <= nxt_idx;
         pend_ff        <= nxt_pend;
         pend_vld_ff    <= nxt_pend_vld;
         wptr_ff        <= nxt_wptr;
         cnt_ff         <= nxt_cnt;
         crc_ff         <= nxt_crc;
         crc_prev_ff    <= nxt_crc_prev;
         link_out_ff    <= nxt_out;
         pec_error_ff   <= nxt_pec_err;
         range_error_ff <= nxt_range_err;
      end
   end

   // Customer storage keeps its contents through reset.
   always_ff @(posedge clk)
   begin
      if (mem_we)
         nv_mem[mem_wa] <= mem_wd;                                       // [R7]
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic rd_go;
   assign rd_go = link_in.rd_req && st_ff == ST_READ && !link_in.byte_valid
                  && !link_in.frame_start && !link_in.frame_stop;

   AST_PWR_DELIVERY: assert property (share_ma > SHARE_LIMIT_MA |=> ##1 secondary_alarm_flags_ff[0]) // [R1]
      else $error("Power delivery alarm missed.");
   AST_INPUT_COUNT: assert property (rd_go && cmd_ff == CMD_INPUT && idx_ff == 8'h00
      |=> link_out_ff.rd_valid && link_out_ff.rd_data == 8'h04) // [R2]
      else $error("Input readback count wrong.");
   AST_INPUT_ORDER: assert property (rd_go && cmd_ff == CMD_INPUT && idx_ff == 8'h03
      |=> link_out_ff.rd_data == $past(pin_word[7:0])) // [R11]
      else $error("Power low byte not third.");
   AST_FW_COUNT: assert property (rd_go && cmd_ff == CMD_FWREV && idx_ff == 8'h00
      |=> link_out_ff.rd_data == 8'h06) // [R3]
      else $error("Revision count wrong.");
   AST_TIMER_LOW: assert property (rd_go && cmd_ff == CMD_TIMER && idx_ff == 8'h01
      |=> link_out_ff.rd_data == $past(hours_ff[7:0])) // [R4]
      else $error("Hours low byte not first.");
   AST_HOURS_TICK: assert property (!hours_load && cyc_ff == HOUR_CYCLES - 40'h1
      && hours_ff != {HOURS_W{1'b1}} |=> hours_ff == $past(hours_ff) + 1'b1) // [R5]
      else $error("Hour counter did not advance.");
   AST_HOURS_MONO: assert property (!hours_load |=> hours_ff >= $past(hours_ff)) // [R6]
      else $error("Hour counter went backwards.");
   AST_PEC_LAST: assert property (rd_go && idx_ff == resp_cnt + 8'h01
      |=> link_out_ff.rd_data == $past(crc_ff)) // [R10]
      else $error("PEC not after data bytes.");
   AST_NV_RANGE: assert property (rd_go && cmd_ff == CMD_NVDATA && idx_ff == 8'h00 && !range_ok
      |=> link_out_ff.rd_data == 8'h00 && range_error_ff) // [R13]
      else $error("Out of range read not refused.");
   AST_NV_FIRST: assert property (rd_go && cmd_ff == CMD_NVDATA && idx_ff == 8'h01 && range_ok
      |=> link_out_ff.rd_data == $past(nv_mem[loc_ff[6:0]])) // [R9]
      else $error("Storage read byte wrong.");

   COV_INPUT_READ: cover property (rd_go && cmd_ff == CMD_INPUT && idx_ff == 8'h05);
   COV_NV_WRITE:   cover property (mem_we ##[1:40] link_in.frame_stop);
   COV_NV_READ:    cover property (rd_go && cmd_ff == CMD_NVDATA && idx_ff == 8'h02);
   COV_HOUR:       cover property (hours_ff == {HOURS_W{1'b1}});
endmodule : rmc_readback_cmds

// *** shared/rmc_pkg.sv ***
// Constants, types and helpers shared by the readback command block.
// How it works
// R1: Flag power delivery alarm when sourced share current exceeds 10 A.
// R2: Command 0xD4 answers count 4, voltage low/high, power low/high, then PEC.
// R3: Firmware command answers count 6, three controllers major/minor in order, then PEC.
// R4: Command 0xD6 answers count 3, three hour bytes low first, then PEC.
// R5: Hours counter runs always, in standby and under main output power alike.
// R6: Hours counter is wide enough for over 1900 years of hours.
// R7: 128 bytes of customer storage are reached through command 0xD9.
// R8: Host writes storage as 0xD9, location, data first to last, then PEC.
// R9: Host reads storage with 0xD9, location, count up to 32, repeated start.
// R10: Block answers start with the data byte count, PEC not counted.
// R11: Multi-byte values go out low byte before high byte.
// R12: Host ends a block read by not acknowledging PEC, then stop.
// R13: Storage access beyond the 128-byte region is refused and flagged.
package rmc_pkg;
   localparam logic [7:0]  CMD_INPUT      = 8'hD4;
   localparam logic [7:0]  CMD_FWREV      = 8'hD5;
   localparam logic [7:0]  CMD_TIMER      = 8'hD6;
   localparam logic [7:0]  CMD_NVDATA     = 8'hD9;
   localparam logic [7:0]  INPUT_COUNT    = 8'h04;
   localparam logic [7:0]  FWREV_COUNT    = 8'h06;
   localparam logic [7:0]  TIMER_COUNT    = 8'h03;
   localparam logic [7:0]  NV_MAX_COUNT   = 8'h20;
   localparam logic [8:0]  NV_SIZE        = 9'h080;
   localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
   localparam logic [7:0]  CRC_POLY       = 8'h07;
   localparam logic [7:0]  ALARM_RST      = 8'h00;
   localparam logic [15:0] SHARE_LIMIT_MA = 16'h2710;
   localparam int          HOURS_W        = 24;
   localparam logic [63:0] CLK_HZ         = 64'h0BEBC200;
   localparam logic [63:0] HOUR_S         = 64'h0000_0E10;
   localparam logic [39:0] HOUR_CYCLES_DFLT = 40'(CLK_HZ * HOUR_S);

   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} rmc_state_t;

   // Byte-level view of the bus transaction layer.
   typedef struct packed {
      logic       frame_start;
      logic       frame_stop;
      logic       byte_valid;
      logic       byte_addr;
      logic       rd_req;
      logic [7:0] byte_data;
   } rmc_link_in_t;

   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
   } rmc_link_out_t;

   // One byte step of the packet error code (CRC-8, polynomial x8+x2+x+1).
   function automatic logic [7:0] rmc_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : rmc_crc8
endpackage : rmc_pkg

// *** tb/rmc_host_model.sv ***
// Behavioural bus host that drives the byte-level link of the readback block.
`timescale 1ns/100ps
module rmc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2C
) (
   input  wire logic                   clk,
   input  wire rmc_pkg::rmc_link_out_t link_out,
   output rmc_pkg::rmc_link_in_t       link_in
);
   import rmc_pkg::*;

   // The link rests idle from time zero so no stray event reaches the block.
   initial link_in = '0;

   // One byte step of the packet error code, kept apart from the block's own helper.
   function automatic logic [7:0] crc8(input logic [7:0] c0, input logic [7:0] d);
      logic [7:0] c;
      c = c0 ^ d;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
      return c;
   endfunction : crc8

   // Drives one link event for one cycle, launched just after a rising edge.
   task automatic put(input logic fs, fp, bv, ba, rr, input logic [7:0] d);
      @(posedge clk);
      link_in <= '{fs, fp, bv, ba, rr, d};
   endtask : put

   // A released data line shows the inverse of its last value, never a stale copy.
   task automatic idle();
      put(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~link_in.byte_data);
   endtask : idle

   // Clocks out one answer byte and waits a bounded time for the registered pulse.
   task automatic rd(output logic [7:0] b);
      b = 'x;
      put(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ~link_in.byte_data);
      idle();
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         if (link_out.rd_valid === 1'b1)
         begin
            b = link_out.rd_data;
            break;
         end
      end
   endtask : rd

   // Runs a whole frame: a write part, then either its code or a repeated-start read.
   task automatic xfer(input logic [7:0] wq[$], input int nrd, input logic bad,
                       output logic [7:0] rq[$]);
      logic [7:0] c;
      logic [7:0] b;
      rq = {};
      put(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ~link_in.byte_data);
      c = crc8(8'h00, {DEV_ADDR, 1'b0});
      put(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, {DEV_ADDR, 1'b0});
      foreach (wq[i])
      begin
         put(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, wq[i]);
         c = crc8(c, wq[i]);
      end
      if (nrd == 0)
         put(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, bad ? ~c : c);
      else
      begin
         put(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, {DEV_ADDR, 1'b1});
         for (int k = 0; k < nrd; k++)
         begin
            rd(b);
            rq.push_back(b);
         end
      end
      // The last byte goes unacknowledged and a stop closes the frame.
      put(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, ~link_in.byte_data);
      idle();
   endtask : xfer
endmodule : rmc_host_model

// *** tb/pmbus_mfr_readback_commands_tb.sv ***
// Self-checking bench for the manufacturer readback command block.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module pmbus_mfr_readback_commands_tb;
   import rmc_pkg::*;
   localparam logic [39:0] HC = 40'd200;
   logic clk, rstn, hours_load, err_clear;
   logic [15:0] share_ma, vin_word, pin_word;
   logic [47:0] fw_revs;
   logic [7:0]  sec_alarm_pins, pri_alarm_pins, sec_flags, pri_flags;
   logic [23:0] hours_preset, hours;
   logic        pec_err, rng_err;
   rmc_link_in_t  link_in;
   rmc_link_out_t link_out;
   logic [31:0] seed = 32'h686A3214;
   logic [7:0]  mem [0:127];
   int          n_errors = 0, compares = 0, cyc = 0;

   rmc_readback_cmds #(.HOUR_CYCLES(HC)) dut (.clk(clk), .rstn(rstn), .link_in(link_in),
      .share_ma(share_ma), .vin_word(vin_word), .pin_word(pin_word), .fw_revs(fw_revs),
      .sec_alarm_pins(sec_alarm_pins), .pri_alarm_pins(pri_alarm_pins), .hours_load(hours_load),
      .hours_preset(hours_preset), .err_clear(err_clear), .link_out_ff(link_out),
      .secondary_alarm_flags_ff(sec_flags), .primary_alarm_flags_ff(pri_flags),
      .hours_ff(hours), .pec_error_ff(pec_err), .range_error_ff(rng_err));
   rmc_host_model host (.clk(clk), .link_out(link_out), .link_in(link_in));

   // Clock generator and free-running cycle count.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // Xorshift source of the random stimulus.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   // Reads an answer and compares it with count and data plus the expected code.
   task automatic chk_read(input string nm, input logic [7:0] wq[$], input logic [7:0] e[$],
                           input int extra);
      logic [7:0] rq[$];
      logic [7:0] c;
      c = host.crc8(8'h00, {host.DEV_ADDR, 1'b0});
      foreach (wq[i]) c = host.crc8(c, wq[i]);
      c = host.crc8(c, {host.DEV_ADDR, 1'b1});
      foreach (e[i]) c = host.crc8(c, e[i]);
      e.push_back(c);
      repeat (extra) e.push_back(8'hFF);
      host.xfer(wq, e.size(), 1'b0, rq);
      foreach (e[i]) `CHK(nm, e[i], rq[i])
      $display("test %s done", nm);
   endtask : chk_read

   // Pulses the error clear and waits for the flags to settle.
   task automatic clr();
      @(posedge clk) err_clear <= 1'b1;
      @(posedge clk) err_clear <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : clr

   // Main sequence of scenarios.
   initial
   begin
      logic [7:0]  wq[$], e[$], rq[$];
      logic [31:0] r;
      int          n, loc, l0;
      int          shv[4] = '{10000, 10001, 0, 65535};
      int          rl[2] = '{120, 0};
      int          rc[2] = '{16, 33};
      rstn = 1'b0; hours_load = 1'b0; err_clear = 1'b0; share_ma = '0; vin_word = '0;
      pin_word = '0; fw_revs = '0; sec_alarm_pins = '0; pri_alarm_pins = '0; hours_preset = '0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("secondary reset", 8'h00, sec_flags)
      `CHK("primary reset", 8'h00, pri_flags)
      r = xs();
      foreach (shv[i])
      begin
         @(posedge clk);
         share_ma <= shv[i][15:0];
         pri_alarm_pins <= r[7:0];
         sec_alarm_pins <= r[15:8];
         repeat (6) @(posedge clk);
         @(negedge clk);
         `CHK("secondary flags", {r[15:9], shv[i] > 10000}, sec_flags)
         `CHK("primary flags", r[7:0], pri_flags)
      end
      $display("test alarms done");
      @(posedge clk);
      r = xs();
      vin_word <= r[15:0];
      pin_word <= r[31:16];
      fw_revs <= 48'({xs(), xs()});
      @(posedge clk);
      chk_read("input", '{CMD_INPUT}, '{INPUT_COUNT, vin_word[7:0], vin_word[15:8],
               pin_word[7:0], pin_word[15:8]}, 0);
      e = {FWREV_COUNT};
      for (int k = 0; k < 6; k++) e.push_back(fw_revs[8*k +: 8]);
      chk_read("firmware", '{CMD_FWREV}, e, 0);
      chk_read("unknown", '{8'hD3}, '{8'h00}, 1);
      @(posedge clk);
      r = xs();
      hours_preset <= {1'b0, r[22:0]};
      hours_load <= 1'b1;
      l0 = cyc;
      @(posedge clk) hours_load <= 1'b0;
      chk_read("timer", '{CMD_TIMER}, '{TIMER_COUNT, hours_preset[7:0], hours_preset[15:8],
               hours_preset[23:16]}, 0);
      while (cyc < l0 + 1100) @(posedge clk);
      @(negedge clk);
      `CHK("hours advance", hours_preset + 24'h000005, hours)
      @(posedge clk);
      hours_preset <= 24'hFFFFFE;
      hours_load <= 1'b1;
      @(posedge clk) hours_load <= 1'b0;
      repeat (500) @(posedge clk);
      @(negedge clk);
      `CHK("hours ceiling", 24'hFFFFFF, hours)
      $display("test hours done");
      r = xs();
      host.xfer('{CMD_NVDATA, 8'h00, r[7:0]}, 0, 1'b1, rq);
      repeat (3) @(negedge clk);
      `CHK("pec error set", 1'b1, pec_err)
      clr();
      `CHK("pec error clear", 1'b0, pec_err)
      $display("test pec done");
      for (int t = 0; t < 3; t++)
      begin
         n = 1 + int'(xs() % 32);
         loc = (t == 0) ? 128 - n : 1 + int'(xs() % (128 - n));
         wq = {CMD_NVDATA, loc[7:0]};
         for (int k = 0; k < n; k++)
         begin
            r = xs();
            wq.push_back(r[7:0]);
            mem[loc + k] = r[7:0];
         end
         host.xfer(wq, 0, 1'b0, rq);
         e = {n[7:0]};
         for (int k = 0; k < n; k++) e.push_back(mem[loc + k]);
         chk_read("storage", '{CMD_NVDATA, loc[7:0], n[7:0]}, e, 0);
         `CHK("no range error", 1'b0, rng_err)
      end
      for (int t = 0; t < 2; t++)
      begin
         chk_read("range", '{CMD_NVDATA, rl[t][7:0], rc[t][7:0]}, '{8'h00}, 0);
         @(negedge clk);
         `CHK("range error set", 1'b1, rng_err)
         clr();
         `CHK("range error clear", 1'b0, rng_err)
      end
      $display("test range done");
      stop_test();
   end

   // Watchdog: the scenarios need a few thousand cycles at most.
   initial
   begin
      repeat (30000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      stop_test();
   end
endmodule : pmbus_mfr_readback_commands_tb
